/* File: design/rxecb_pkg.sv */
// rxecb_pkg: offsets, field positions, reset values and rate codes
// for the receive-port error count and return-link configuration slice.
// assumes an 8-bit register port with an 8-bit address.
package rxecb_pkg;

  localparam logic [7:0] ADDR_PAR_HI   = 8'h55;
  localparam logic [7:0] ADDR_PAR_LO   = 8'h56;
  localparam logic [7:0] ADDR_BUILT_IN_SELF_TEST_CNT = 8'h57;
  localparam logic [7:0] ADDR_BCC_CFG  = 8'h58;
  localparam logic [7:0] ADDR_RSVD_A   = 8'h59;
  localparam logic [7:0] ADDR_RSVD_B   = 8'h5a;
  localparam logic [7:0] ADDR_REMOTE_SERIALIZER_ID   = 8'h5b;

  localparam int BIT_PASS_ALL   = 7;
  localparam int BIT_PASS_MATCH = 6;
  localparam int BIT_AUTO_ACK   = 5;
  localparam int BIT_BC_EN      = 4;
  localparam int BIT_CRC_EN     = 3;
  localparam int BIT_RATE_HI    = 1;
  localparam int BIT_RATE_LO    = 0;
  localparam int BIT_HOLD_ID    = 0;

  localparam logic [7:0] RST_BCC_CFG = 8'h18;
  localparam logic [7:0] RST_REMOTE_SERIALIZER_ID  = 8'h00;
  localparam logic [7:0] RST_RSVD    = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;

  // every bit of the config register is written and read back
  localparam logic [7:0] BCC_CFG_MASK = 8'hff;

  localparam logic [1:0] RATE_2P5M  = 2'h0;
  localparam logic [1:0] RATE_1P56M = 2'h1;

  // return-link bit periods in ns and derived core-clock counts
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RATE_2P5M_NS    = 400;
  localparam int RATE_1P56M_NS   = 640;
  localparam int RATE_2P5M_CYC   = RATE_2P5M_NS / CLK_PERIOD_NS;
  localparam int RATE_1P56M_CYC  = RATE_1P56M_NS / CLK_PERIOD_NS;

endpackage

/* File: design/rxecb_sync.sv */
// rxecb_sync: two-flop synchroniser for one level from outside the
// core clock domain. assumes i_core_clk and an active-low async reset.
`timescale 1ns/100ps
`default_nettype none
module rxecb_sync (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output var  logic o_sync
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

/* File: design/rxecb_top.sv */
// rxecb_top: parity error counter, self-test count, return-link
// configuration and remote serializer id registers of one receive port.
// assumes a byte register port (address, write/read strobes) on the core
// clock and one-cycle event pulses from same-clock receiver logic.
//
// Overview of operation
// - low count byte is read-only and clears itself on any read
// - built-in self-test error count is read-only at its own register
// - pass-all bit forwards every local i2c transaction to the serializer
// - matched pass bit forwards only transactions matching the decoder
// - auto-ack bit acks every i2c write locally, ignoring lock and remote
// - return link enable gates camera mode, resets to one, display always on
// - crc generation on return link while crc enable is one, reset one
// - rate field: 00 gives 2.5 Mbps, 01 gives a 6-clock (600 ns) bit, about 1.67 Mbps, strap loadable
// - remote id writable, normally auto-loaded from the remote serializer
// - hold bit stops auto-loading and keeps the written id
// - parity status flag above threshold, cleared with the count bytes
`timescale 1ns/100ps
`default_nettype none
module rxecb_top #(
  parameter int CNT_W = 16
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  // register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output var  logic [7:0] o_reg_rdata,
  // receiver events, same clock
  input  wire logic       i_parity_err,
  input  wire logic       i_lock_detect,
  input  wire logic [7:0] i_self_test_error_count,
  input  wire logic [CNT_W-1:0] i_par_threshold,
  input  wire logic       i_id_valid,
  input  wire logic [6:0] i_id_value,
  // local i2c decode
  input  wire logic       i_i2c_start,
  input  wire logic       i_i2c_match,
  input  wire logic       i_i2c_write,
  // pins
  input  wire logic       i_camera_mode,
  input  wire logic [1:0] i_rate_strap,
  input  wire logic       i_strap_load,
  // outputs
  output var  logic       o_parity_flag,
  output var  logic       o_i2c_forward,
  output var  logic       o_i2c_local_ack,
  output var  logic       o_bc_enable,
  output var  logic       o_bc_crc_enable,
  output var  logic [1:0] o_bc_rate,
  output var  logic       o_bc_bit_tick
);

  logic [CNT_W-1:0] par_count_ff;
  logic [CNT_W-1:0] nxt_par_count;
  logic [7:0]       bcc_cfg_ff;
  logic [7:0]       rsvd_a_ff;
  logic [7:0]       rsvd_b_ff;
  logic [7:0]       remote_serializer_id_ff;
  logic [7:0]       rdata_ff;
  logic             parity_flag_ff;
  logic             fwd_ff;
  logic             ack_ff;
  logic             bc_en_ff;
  logic             crc_en_ff;
  logic [1:0]       rate_ff;
  logic             tick_ff;
  logic [3:0]       tick_cnt_ff;
  logic             strap_sync;
  logic             strap_dly_ff;
  logic             camera_sync;
  logic [1:0]       strap_val_sync;
  logic             rd_lo;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign rd_lo = i_reg_rd && hit(i_reg_addr, rxecb_pkg::ADDR_PAR_LO);

  rxecb_sync u_strap_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_strap_load),
    .o_sync     (strap_sync)
  );

  rxecb_sync u_cam_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_camera_mode),
    .o_sync     (camera_sync)
  );

  // strap value pins take the same two flops as the load pin, so they line up
  rxecb_sync u_strap_hi_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_rate_strap[1]),
    .o_sync     (strap_val_sync[1])
  );

  rxecb_sync u_strap_lo_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (i_rate_strap[0]),
    .o_sync     (strap_val_sync[0])
  );

  // saturate rather than wrap so a long run never reads as few errors
  always_comb begin
    nxt_par_count = par_count_ff;
    if (i_lock_detect || rd_lo) begin
      nxt_par_count = '0;
      if (i_parity_err) begin
        nxt_par_count = CNT_W'(1);
      end
    end else if (i_parity_err && !(&par_count_ff)) begin
      nxt_par_count = par_count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_count_ff <= '0;
    end else begin
      par_count_ff <= nxt_par_count;
    end
  end

  // status flag: set on threshold exceeded wins over the clear
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      parity_flag_ff <= 1'b0;
    end else if (nxt_par_count > i_par_threshold) begin
      parity_flag_ff <= 1'b1;
    end else if (i_lock_detect || rd_lo) begin
      parity_flag_ff <= 1'b0;
    end
  end

  // strap is caught on a rising edge of the synchronised load pin
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_dly_ff <= 1'b0;
    end else begin
      strap_dly_ff <= strap_sync;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bcc_cfg_ff <= rxecb_pkg::RST_BCC_CFG;
    end else if (i_reg_wr && hit(i_reg_addr, rxecb_pkg::ADDR_BCC_CFG)) begin
      bcc_cfg_ff <= i_reg_wdata & rxecb_pkg::BCC_CFG_MASK;
    end else if (strap_sync && !strap_dly_ff) begin
      bcc_cfg_ff[rxecb_pkg::BIT_RATE_HI:rxecb_pkg::BIT_RATE_LO]
        <= strap_val_sync;
    end
  end

  // reserved bytes are plain storage, read back as written
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rsvd_a_ff <= rxecb_pkg::RST_RSVD;
    end else if (i_reg_wr && hit(i_reg_addr, rxecb_pkg::ADDR_RSVD_A)) begin
      rsvd_a_ff <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rsvd_b_ff <= rxecb_pkg::RST_RSVD;
    end else if (i_reg_wr && hit(i_reg_addr, rxecb_pkg::ADDR_RSVD_B)) begin
      rsvd_b_ff <= i_reg_wdata;
    end
  end

  // software write has priority over an auto-load in the same cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      remote_serializer_id_ff <= rxecb_pkg::RST_REMOTE_SERIALIZER_ID;
    end else if (i_reg_wr && hit(i_reg_addr, rxecb_pkg::ADDR_REMOTE_SERIALIZER_ID)) begin
      remote_serializer_id_ff <= i_reg_wdata;
    end else if (i_id_valid && !remote_serializer_id_ff[rxecb_pkg::BIT_HOLD_ID]) begin
      remote_serializer_id_ff[7:1] <= i_id_value;
    end
  end

  // read data registered; a read of an unmapped address returns zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd) begin
      if (hit(i_reg_addr, rxecb_pkg::ADDR_PAR_HI)) begin
        rdata_ff <= par_count_ff[15:8];
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_PAR_LO)) begin
        rdata_ff <= par_count_ff[7:0];
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_BUILT_IN_SELF_TEST_CNT)) begin
        rdata_ff <= i_self_test_error_count;
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_BCC_CFG)) begin
        rdata_ff <= bcc_cfg_ff;
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_RSVD_A)) begin
        rdata_ff <= rsvd_a_ff;
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_RSVD_B)) begin
        rdata_ff <= rsvd_b_ff;
      end else if (hit(i_reg_addr, rxecb_pkg::ADDR_REMOTE_SERIALIZER_ID)) begin
        rdata_ff <= remote_serializer_id_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // i2c forwarding and local acknowledge decisions per transaction
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_ff <= 1'b0;
    end else begin
      fwd_ff <= i_i2c_start &&
                (bcc_cfg_ff[rxecb_pkg::BIT_PASS_ALL] ||
                 (bcc_cfg_ff[rxecb_pkg::BIT_PASS_MATCH] &&
                  i_i2c_match));
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_i2c_start && i_i2c_write &&
                bcc_cfg_ff[rxecb_pkg::BIT_AUTO_ACK];
    end
  end

  // display mode keeps the return link on whatever bit 4 holds
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bc_en_ff <= 1'b1;
    end else begin
      bc_en_ff <= !camera_sync || bcc_cfg_ff[rxecb_pkg::BIT_BC_EN];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      crc_en_ff <= 1'b1;
    end else begin
      crc_en_ff <= bcc_cfg_ff[rxecb_pkg::BIT_CRC_EN];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_ff <= rxecb_pkg::RATE_2P5M;
    end else begin
      rate_ff <=
        bcc_cfg_ff[rxecb_pkg::BIT_RATE_HI:rxecb_pkg::BIT_RATE_LO];
    end
  end

  // last count of one return-link bit; reserved codes run at 2.5 Mbps
  function automatic logic [3:0] bit_last(input logic [1:0] rate);
    if (rate == rxecb_pkg::RATE_1P56M) begin
      bit_last = 4'(rxecb_pkg::RATE_1P56M_CYC - 1);
    end else begin
      bit_last = 4'(rxecb_pkg::RATE_2P5M_CYC - 1);
    end
  endfunction

  // wrap on >= so a switch to a faster rate never overruns the end count
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_ff <= 4'h0;
      tick_ff     <= 1'b0;
    end else if (!bc_en_ff) begin
      tick_cnt_ff <= 4'h0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= bit_last(rate_ff)) begin
      tick_cnt_ff <= 4'h0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 4'h1;
      tick_ff     <= 1'b0;
    end
  end

  assign o_reg_rdata     = rdata_ff;
  assign o_parity_flag   = parity_flag_ff;
  assign o_i2c_forward   = fwd_ff;
  assign o_i2c_local_ack = ack_ff;
  assign o_bc_enable     = bc_en_ff;
  assign o_bc_crc_enable = crc_en_ff;
  assign o_bc_rate       = rate_ff;
  assign o_bc_bit_tick   = tick_ff;

endmodule
`default_nettype wire

/* File: testbench/rxecb_sva.sv */
// rxecb_sva: port assertions for the error count and config slice
// assumes the core clock and active-low reset of rxecb_top
`timescale 1ns/100ps
`default_nettype none
module rxecb_sva #(
  parameter int CNT_W = 16
) (
  input wire logic             i_core_clk,
  input wire logic             i_resetn,
  input wire logic [7:0]       i_reg_addr,
  input wire logic             i_reg_rd,
  input wire logic [7:0]       o_reg_rdata,
  input wire logic             i_parity_err,
  input wire logic             i_lock_detect,
  input wire logic [7:0]       i_self_test_error_count,
  input wire logic [CNT_W-1:0] i_par_threshold,
  input wire logic             i_i2c_start,
  input wire logic             i_i2c_write,
  input wire logic             i_camera_mode,
  input wire logic             o_parity_flag,
  input wire logic             o_i2c_forward,
  input wire logic             o_i2c_local_ack,
  input wire logic             o_bc_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire lo_rd = i_reg_rd && i_reg_addr == 8'h56;
  wire hi_rd = i_reg_rd && i_reg_addr == 8'h55;
  fwd_cause_a: assert property (
    o_i2c_forward |-> $past(i_i2c_start)) else $error("stray forward");
  ack_cause_a: assert property (
    o_i2c_local_ack |-> $past(i_i2c_start && i_i2c_write))
    else $error("stray local ack");
  lock_clear_a: assert property (
    i_lock_detect && !i_parity_err ##1 lo_rd |=> o_reg_rdata == 8'h00)
    else $error("lock did not clear count");
  lo_clear_a: assert property (
    lo_rd && !i_parity_err ##1 lo_rd |=> o_reg_rdata == 8'h00)
    else $error("low byte not cleared by read");
  hi_clear_a: assert property (
    lo_rd && !i_parity_err ##1 hi_rd |=> o_reg_rdata == 8'h00)
    else $error("high byte not cleared by low read");
  built_in_self_test_read_a: assert property (
    i_reg_rd && i_reg_addr == 8'h57 |=>
    o_reg_rdata == $past(i_self_test_error_count)) else $error("bad built_in_self_test read");
  flag_set_a: assert property (
    i_parity_err && i_par_threshold == '0 |=> o_parity_flag)
    else $error("flag not raised");
  display_bc_a: assert property (
    !i_camera_mode [*4] |-> o_bc_enable) else $error("display link off");
  cover property (lo_rd ##1 hi_rd);
  cover property (o_i2c_forward);
  cover property (o_parity_flag);
endmodule
bind rxecb_top rxecb_sva #(.CNT_W(CNT_W)) rxecb_sva_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_parity_err(i_parity_err), .i_lock_detect(i_lock_detect),
  .i_self_test_error_count(i_self_test_error_count), .i_par_threshold(i_par_threshold),
  .i_i2c_start(i_i2c_start), .i_i2c_write(i_i2c_write),
  .i_camera_mode(i_camera_mode), .o_parity_flag(o_parity_flag),
  .o_i2c_forward(o_i2c_forward), .o_i2c_local_ack(o_i2c_local_ack),
  .o_bc_enable(o_bc_enable));
`default_nettype wire

/* File: testbench/rxecb_ser_model.sv */
// rxecb_ser_model: remote serializer, sends its id as a one-cycle pulse
// assumes the bench raises i_send just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module rxecb_ser_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_send,
  input  wire logic [6:0] i_id,
  output var  logic       o_id_valid,
  output var  logic [6:0] o_id_value
);
  always_ff @(posedge i_core_clk) begin
    o_id_valid <= i_send;
    // outside a send the lines carry the inverse, never a stale id
    o_id_value <= i_send ? i_id : ~i_id;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// tb_top: self-checking bench for rxecb_top with a serializer model
// assumes a 10 MHz core clock; inputs change 1 ns after each edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb_top;
  logic        clk = 0, rstn = 0, rd = 0, wr = 0, perr = 0, lock = 0;
  logic        st = 0, mt = 0, wt = 0, cam = 0, sl = 0, snd = 0, idv;
  logic [7:0]  addr = '0, wd = '0, built_in_self_test = '0, rdata;
  logic [15:0] thr = '0;
  logic [1:0]  strap = '0, rate;
  logic [6:0]  idi = '0, idval;
  logic        flag, fwd, ack, bce, crc, tick;
  int          fails = 0, checks = 0, n, k;
  rxecb_ser_model rxecb_ser_model_i (.i_core_clk(clk), .i_send(snd),
    .i_id(idi), .o_id_valid(idv), .o_id_value(idval));
  rxecb_top #(.CNT_W(16)) rxecb_top_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .i_parity_err(perr), .i_lock_detect(lock),
    .i_self_test_error_count(built_in_self_test), .i_par_threshold(thr), .i_id_valid(idv),
    .i_id_value(idval), .i_i2c_start(st), .i_i2c_match(mt),
    .i_i2c_write(wt), .i_camera_mode(cam), .i_rate_strap(strap),
    .i_strap_load(sl), .o_parity_flag(flag), .o_i2c_forward(fwd),
    .o_i2c_local_ack(ack), .o_bc_enable(bce), .o_bc_crc_enable(crc),
    .o_bc_rate(rate), .o_bc_bit_tick(tick));
  initial forever #50 clk = ~clk;
  function automatic logic [1:0] exp_i2c(logic [4:0] c);
    return {c[4] | (c[3] & c[1]), c[2] & c[0]};
  endfunction
  task automatic nx;
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, d);
    addr = a;
    wd = d;
    wr = 1;
    nx;
    wr = 0;
    nx;
  endtask
  task automatic chk_rd(input logic [7:0] a, e);
    addr = a;
    rd = 1;
    nx;
    rd = 0;
    `CHK(rdata, e)
    nx;
  endtask
  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        nx;
        g++;
      end while (tick !== 1'b1 && g < 20);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    k = $urandom(96);
    repeat (6) @(posedge clk);
    #1;
    rstn = 1;
    `CHK({bce, crc, rate}, 4'hc)
    chk_rd(8'h58, 8'h18);
    chk_rd(8'h5b, 8'h00);
    chk_rd(8'h55, 8'h00);
    chk_rd(8'h56, 8'h00);
    $display("reset test done");
    n = $urandom_range(600, 256);
    thr = 16'($urandom_range(600));
    perr = 1;
    repeat (n) nx;
    perr = 0;
    `CHK(flag, n > thr)
    chk_rd(8'h55, n[15:8]);
    addr = 8'h56;
    rd = 1;
    nx;
    `CHK(rdata, n[7:0])
    addr = 8'h55;
    nx;
    rd = 0;
    `CHK(rdata, 8'h00)
    nx;
    `CHK(flag, 1'b0)
    thr = '0;
    perr = 1;
    repeat (2) nx;
    perr = 0;
    lock = 1;
    `CHK(flag, 1'b1)
    nx;
    lock = 0;
    `CHK(flag, 1'b0)
    addr = 8'h56;
    rd = 1;
    nx;
    `CHK(rdata, 8'h00)
    nx;
    rd = 0;
    `CHK(rdata, 8'h00)
    nx;
    built_in_self_test = 8'($urandom);
    wreg(8'h57, ~built_in_self_test);
    chk_rd(8'h57, built_in_self_test);
    $display("count test done");
    for (int i = 0; i < 32; i++) begin
      wreg(8'h58, {i[4:2], 5'h18});
      mt = i[1];
      wt = i[0];
      st = 1;
      nx;
      st = 0;
      `CHK({fwd, ack}, exp_i2c(i[4:0]))
    end
    $display("i2c test done");
    wreg(8'h58, 8'h20);
    cam = 1;
    repeat (4) nx;
    `CHK({bce, crc}, 2'b00)
    cam = 0;
    repeat (4) nx;
    `CHK(bce, 1'b1)
    for (int r = 0; r < 2; r++) begin
      wreg(8'h58, 8'h38 | 8'(r));
      `CHK(rate, 2'(r))
      tick_gap(k);
      `CHK(k, r ? rxecb_pkg::RATE_1P56M_CYC : rxecb_pkg::RATE_2P5M_CYC)
    end
    strap = 2'h2 | 2'($urandom_range(1));
    sl = 1;
    repeat (5) nx;
    sl = 0;
    chk_rd(8'h58, 8'h38 | 8'(strap));
    tick_gap(k);
    `CHK(k, rxecb_pkg::RATE_2P5M_CYC)
    $display("link test done");
    idi = 7'($urandom);
    wreg(8'h5b, 8'ha4);
    chk_rd(8'h5b, 8'ha4);
    snd = 1;
    nx;
    snd = 0;
    nx;
    chk_rd(8'h5b, {idi, 1'b0});
    wreg(8'h5b, 8'ha5);
    snd = 1;
    nx;
    snd = 0;
    nx;
    chk_rd(8'h5b, 8'ha5);
    $display("id test done");
    stop_test;
  end
  initial begin
    // nearly four times the longest run of the tests above
    #(3000 * 100);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
